// >>> verilog/sync_slave_map.vh
// register map, field positions and reset values of the synchronous slave serial port
// Summary of operation
// RQ1: slave mode when sync and port enable set, clock source select clear.
// RQ2: the far master supplies the shift clock; the device never drives it.
// RQ3: with two words written, the first moves to the shift register and sends at once.
// RQ4: while the first shifts, the second stays held and buffer-empty flag stays clear.
// RQ5: after the first leaves, the held word moves in, then buffer-empty flag sets.
// RQ6: buffer-empty with transmit interrupt enable raises the wake request.
// RQ7: software clears both receive enables before slave transmission.
// RQ8: with transmit enabled, writing the holding register starts a transmission.
// RQ9: nine-bit transmit sends the ninth bit from the transmit ninth bit field.
// RQ10: single receive enable is ignored in slave mode; only continuous receive counts.
// RQ11: continuous receive keeps working during sleep or idle; here reception stops while CE_I is low.
// RQ12: a finished word moves to the receive buffer; enabled interrupt wakes the device.
// RQ13: receive complete flag sets when a word finishes; interrupt when enabled.
// RQ14: received ninth bit and error flags read from receive status control.
// RQ15: eight received data bits read from the receive buffer register.
// RQ16: clearing continuous receive enable clears the reception error.
// RQ17: software sets global and peripheral interrupt enables, bits 7 and 6.
// RQ18: transmit shift empty bit is set whenever the shift register is empty.
`ifndef SYNC_SLAVE_MAP_VH
`define SYNC_SLAVE_MAP_VH
`define OFF_RCV_STAT 12'h000
`define OFF_TX_HOLD 12'h004
`define OFF_TX_STAT 12'h008
`define OFF_BAUD_CTL 12'h00c
`define OFF_BAUD_HI 12'h010
`define OFF_BAUD_LO 12'h014
`define OFF_RCV_BUF 12'h018
`define OFF_FLAGS 12'h01c
// receive status control fields
`define RS_PORT_EN 7
`define RS_NINE_RX 6
`define RS_SINGLE_RX 5
`define RS_CONT_RX 4
`define RS_ADDR_EN 3
`define RS_FRAME_ERR 2
`define RS_OVERRUN 1
`define RS_RX_NINTH 0
// transmit status control fields
`define TS_CLK_SRC 7
`define TS_NINE_TX 6
`define TS_TX_EN 5
`define TS_SYNC 4
`define TS_SHIFT_EMPTY 1
`define TS_TX_NINTH 0
// flag register fields
`define FL_TX_EMPTY 0
`define FL_RX_DONE 1
`define FL_TX_IE 2
`define FL_RX_IE 3
`define RST_TX_STAT 8'h02
`define RST_RCV_STAT 8'h00
`endif

// >>> verilog/sync_slave_pipe.v
// three-stage input synchroniser with agreement-based change detection
`timescale 1ns/1ns
module sync_slave_pipe #(
    parameter WIDTH = 2
)(
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] level_o,
    output wire [WIDTH-1:0] rise_o,
    output wire [WIDTH-1:0] fall_o
);
    reg [WIDTH-1:0] s1;
    reg [WIDTH-1:0] s2;
    reg [WIDTH-1:0] s3;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : bit_sync
            always @(posedge clk_i)
            begin
                if (!rst_n_i)
                begin
                    s1[g] <= 1'b0;
                    s2[g] <= 1'b0;
                    s3[g] <= 1'b0;
                    level_o[g] <= 1'b0;
                end
                else if (ce_i)
                begin
                    s1[g] <= async_i[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    // change counts only once stages two and three agree
                    if (s2[g] == s3[g])
                        level_o[g] <= s3[g];
                end
            end
            assign rise_o[g] = ce_i && (s2[g] == s3[g]) && s3[g] && !level_o[g];
            assign fall_o[g] = ce_i && (s2[g] == s3[g]) && !s3[g] && level_o[g];
        end
    endgenerate
endmodule

// >>> verilog/sync_slave_serial_port.v
// synchronous slave serial port with apb register access
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`include "sync_slave_map.vh"
module sync_slave_serial_port (
    // clock, reset, enable
    input wire MCLK_I,
    input wire RST_N_I,
    input wire CE_I,
    // apb slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire PREADY_O,
    output wire PSLVERR_O,
    // serial link
    input wire SHIFT_CLK_I,
    input wire DATA_IN_I,
    output reg DATA_OUT_O,
    output reg DATA_OE_O,
    // wake requests
    output wire TX_WAKE_O,
    output wire RX_WAKE_O
);
    reg [7:0] rcv_stat;
    reg [7:0] tx_stat;
    reg [7:0] baud_ctl;
    reg [7:0] baud_hi;
    reg [7:0] baud_lo;
    reg [7:0] tx_hold;
    reg tx_hold_ninth;
    reg tx_hold_full;
    reg [8:0] tx_shift;
    reg [3:0] tx_count;
    reg tx_busy;
    reg [8:0] rx_shift;
    reg [3:0] rx_count;
    reg [7:0] rcv_buf;
    reg rcv_buf_ninth;
    reg rx_done;
    reg tx_empty_flag;
    reg tx_ie;
    reg rx_ie;
    reg [31:0] prdata;
    wire [1:0] pin_level;
    wire [1:0] pin_rise;
    wire [1:0] pin_fall;
    wire slave_mode;
    wire cont_rx;
    wire [3:0] tx_bits;
    wire [3:0] rx_bits;
    wire wr;
    wire rd;
    wire rd_buf;
    wire mapped;
    wire load_shift;
    wire rx_word_done;

    sync_slave_pipe #(.WIDTH(2)) pins (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .async_i({DATA_IN_I, SHIFT_CLK_I}),
        .level_o(pin_level),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    // RQ1: slave mode select
    assign slave_mode = rcv_stat[`RS_PORT_EN] && tx_stat[`TS_SYNC] && !tx_stat[`TS_CLK_SRC];
    // RQ10: single receive ignored
    assign cont_rx = slave_mode && rcv_stat[`RS_CONT_RX];
    // RQ9: nine bit frame length
    assign tx_bits = tx_stat[`TS_NINE_TX] ? 4'h9 : 4'h8;
    assign rx_bits = rcv_stat[`RS_NINE_RX] ? 4'h9 : 4'h8;

    // apb answers in the access cycle, no wait states
    assign wr = PSEL_I && PENABLE_I && PWRITE_I && CE_I;
    assign rd = PSEL_I && PENABLE_I && !PWRITE_I && CE_I;
    assign rd_buf = rd && (PADDR_I == `OFF_RCV_BUF);
    assign mapped = (PADDR_I <= `OFF_FLAGS) && (PADDR_I[1:0] == 2'b00);
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
    assign PRDATA_O = prdata;

    // RQ3: empty shift register takes the held word at once
    assign load_shift = slave_mode && tx_stat[`TS_TX_EN] && tx_hold_full && !tx_busy;
    assign rx_word_done = cont_rx && pin_fall[0] && (rx_count == rx_bits - 4'h1);

    // RQ6: transmit wake request
    assign TX_WAKE_O = tx_empty_flag && tx_ie;
    // RQ12: receive wake request
    assign RX_WAKE_O = rx_done && rx_ie;

    always @*
    begin
        case (PADDR_I)
            `OFF_RCV_STAT: prdata = {24'h000000, rcv_stat};
            `OFF_TX_STAT: prdata = {24'h000000, tx_stat[7:2], !tx_busy, tx_stat[0]};
            `OFF_BAUD_CTL: prdata = {24'h000000, baud_ctl};
            `OFF_BAUD_HI: prdata = {24'h000000, baud_hi};
            `OFF_BAUD_LO: prdata = {24'h000000, baud_lo};
            // RQ15: received data bits
            `OFF_RCV_BUF: prdata = {24'h000000, rcv_buf};
            `OFF_FLAGS: prdata = {28'h0000000, rx_ie, tx_ie, rx_done, tx_empty_flag};
            default: prdata = 32'h00000000;
        endcase
    end

    always @(posedge MCLK_I)
    begin
        if (!RST_N_I)
        begin
            rcv_stat <= `RST_RCV_STAT;
            tx_stat <= `RST_TX_STAT;
            baud_ctl <= 8'h00;
            baud_hi <= 8'h00;
            baud_lo <= 8'h00;
            tx_hold <= 8'h00;
            tx_hold_ninth <= 1'b0;
            tx_hold_full <= 1'b0;
            tx_shift <= 9'h000;
            tx_count <= 4'h0;
            tx_busy <= 1'b0;
            rx_shift <= 9'h000;
            rx_count <= 4'h0;
            rcv_buf <= 8'h00;
            rcv_buf_ninth <= 1'b0;
            rx_done <= 1'b0;
            tx_empty_flag <= 1'b1;
            tx_ie <= 1'b0;
            rx_ie <= 1'b0;
            DATA_OUT_O <= 1'b0;
            DATA_OE_O <= 1'b0;
        end
        else if (CE_I)
        begin
            // register writes
            if (wr && PADDR_I == `OFF_RCV_STAT)
            begin
                rcv_stat[7:3] <= PWDATA_I[7:3];
                // RQ16: clearing continuous receive clears errors
                if (!PWDATA_I[`RS_CONT_RX])
                    rcv_stat[2:1] <= 2'b00;
            end
            if (wr && PADDR_I == `OFF_TX_STAT)
            begin
                tx_stat[7:2] <= PWDATA_I[7:2];
                tx_stat[0] <= PWDATA_I[0];
            end
            if (wr && PADDR_I == `OFF_BAUD_CTL)
                baud_ctl <= PWDATA_I[7:0];
            if (wr && PADDR_I == `OFF_BAUD_HI)
                baud_hi <= PWDATA_I[7:0];
            if (wr && PADDR_I == `OFF_BAUD_LO)
                baud_lo <= PWDATA_I[7:0];
            if (wr && PADDR_I == `OFF_FLAGS)
            begin
                tx_ie <= PWDATA_I[`FL_TX_IE];
                rx_ie <= PWDATA_I[`FL_RX_IE];
            end
            // RQ18: shift empty status mirrors the shift register
            tx_stat[`TS_SHIFT_EMPTY] <= !tx_busy;

            // RQ8: holding register write starts a transmission
            if (wr && PADDR_I == `OFF_TX_HOLD)
            begin
                tx_hold <= PWDATA_I[7:0];
                // RQ9: ninth bit latched with the word
                tx_hold_ninth <= tx_stat[`TS_TX_NINTH];
                tx_hold_full <= 1'b1;
                // RQ4: flag stays clear while a word is held
                tx_empty_flag <= 1'b0;
            end
            else if (load_shift)
            begin
                tx_hold_full <= 1'b0;
                // RQ5: flag sets once the held word has moved in
                tx_empty_flag <= 1'b1;
            end

            // transmit shifter: data changes on the falling edge of the shift clock
            if (!slave_mode || !tx_stat[`TS_TX_EN])
            begin
                tx_busy <= 1'b0;
                DATA_OE_O <= 1'b0;
            end
            else if (load_shift)
            begin
                tx_shift <= {tx_hold_ninth, tx_hold};
                tx_count <= 4'h0;
                tx_busy <= 1'b1;
                DATA_OE_O <= 1'b1;
                DATA_OUT_O <= tx_hold[0];
            end
            else if (tx_busy && pin_fall[0])
            begin
                // RQ5: word leaves after its last bit is taken
                if (tx_count == tx_bits - 4'h1)
                    tx_busy <= 1'b0;
                else
                begin
                    tx_count <= tx_count + 4'h1;
                    tx_shift <= {1'b0, tx_shift[8:1]};
                    DATA_OUT_O <= tx_shift[1];
                end
            end

            // RQ11: receive steps on link clock falls sampled through MCLK_I, and stops while CE_I is low
            if (!cont_rx)
                rx_count <= 4'h0;
            else if (pin_fall[0])
            begin
                rx_shift <= {pin_level[1], rx_shift[8:1]};
                rx_count <= rx_word_done ? 4'h0 : rx_count + 4'h1;
            end
            if (rx_word_done)
            begin
                // RQ12: completed word moves to the receive buffer
                if (rcv_stat[`RS_NINE_RX])
                begin
                    rcv_buf <= rx_shift[8:1];
                    rcv_buf_ninth <= pin_level[1];
                end
                else
                begin
                    rcv_buf <= {pin_level[1], rx_shift[8:2]};
                    rcv_buf_ninth <= 1'b0;
                end
                // RQ14: overrun when unread word is overwritten
                if (rx_done && !rd_buf)
                    rcv_stat[`RS_OVERRUN] <= 1'b1;
            end
            // RQ13: receive complete flag, set wins over read clear
            if (rx_word_done)
                rx_done <= 1'b1;
            else if (rd_buf)
                rx_done <= 1'b0;
            // RQ14: ninth bit visible in status
            rcv_stat[`RS_RX_NINTH] <= rcv_buf_ninth;
        end
    end
endmodule

// >>> testbench/sync_slave_props.sv
// concurrent checks on the serial port's apb and link pins
`timescale 1ns/1ns
module sync_slave_props (
    // clock, reset, enable
    input logic MCLK_I,
    input logic RST_N_I,
    input logic CE_I,
    // apb
    input logic PSEL_I,
    input logic PENABLE_I,
    input logic PWRITE_I,
    input logic [11:0] PADDR_I,
    input logic [31:0] PWDATA_I,
    input logic [31:0] PRDATA_O,
    input logic PREADY_O,
    input logic PSLVERR_O,
    // link and wake
    input logic SHIFT_CLK_I,
    input logic DATA_IN_I,
    input logic DATA_OUT_O,
    input logic DATA_OE_O,
    input logic TX_WAKE_O,
    input logic RX_WAKE_O
);
    wire acc = PSEL_I && PENABLE_I && CE_I;
    wire wr_now = acc && PWRITE_I;
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_N_I);
    sequence hold_write;
        wr_now && PADDR_I == 12'h004;
    endsequence
    // a word shifts for many cycles, so a second write this close is always held
    sequence two_holds;
        hold_write ##[1:8] hold_write;
    endsequence
    // a load right after a holding write moves the line with no clock, so skip it
    sequence word_moving;
        DATA_OE_O && $past(DATA_OE_O) && $changed(DATA_OUT_O) && !$past(wr_now, 2);
    endsequence
    pready_high_a: assert property (PREADY_O)
        else $error("pready low");
    unmapped_err_a: assert property (acc |-> PSLVERR_O == (PADDR_I > 12'h01c || PADDR_I[1:0] != 0))
        else $error("slave error wrong");
    upper_zero_a: assert property (acc && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0)
        else $error("read data upper bits set");
    held_word_a: assert property (two_holds |=> !TX_WAKE_O [*2])
        else $error("buffer empty while word held");
    tx_wake_drop_a: assert property ($fell(TX_WAKE_O) |-> $past(wr_now))
        else $error("tx wake dropped without write");
    rx_wake_drop_a: assert property ($fell(RX_WAKE_O) |-> $past(acc))
        else $error("rx wake dropped without access");
    bit_after_fall_a: assert property (word_moving |-> !$past(SHIFT_CLK_I, 3))
        else $error("data out moved without shift clock fall");
    drive_start_a: assert property ($rose(DATA_OE_O) |-> $past(wr_now) || $past(wr_now, 2))
        else $error("drive began without a write");
    reset_quiet_a: assert property (disable iff (1'b0) !RST_N_I |=> !DATA_OE_O && !TX_WAKE_O)
        else $error("outputs active in reset");
endmodule
bind sync_slave_serial_port sync_slave_props i_sync_slave_props (.MCLK_I(MCLK_I),
    .RST_N_I(RST_N_I), .CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SHIFT_CLK_I(SHIFT_CLK_I),
    .DATA_IN_I(DATA_IN_I), .DATA_OUT_O(DATA_OUT_O), .DATA_OE_O(DATA_OE_O),
    .TX_WAKE_O(TX_WAKE_O), .RX_WAKE_O(RX_WAKE_O));

// >>> testbench/ext_shift_master.sv
// far-end master that makes the shift clock and swaps bits, lsb first
`timescale 1ns/1ns
module ext_shift_master (
    input wire clk_i,
    output logic shift_clk_o,
    output logic data_o,
    input wire data_i
);
    initial
    begin
        shift_clk_o = 1'b1;
        data_o = 1'b0;
    end
    task xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
        rx = 9'h0;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            data_o <= tx[i];
            repeat (2) @(posedge clk_i);
            rx[i] = data_i;
            shift_clk_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            shift_clk_o <= 1'b1;
            @(posedge clk_i);
        end
        // clock idles high; data line shows a stale-free value
        data_o <= ~data_o;
    endtask
endmodule

// >>> testbench/tb_top.sv
// register-level bench for the synchronous slave serial port
`timescale 1ns/1ns
`include "sync_slave_map.vh"
module tb_top;
    logic mclk = 0, rst_n = 0, ce = 1, psel = 0, pen = 0, pwr = 0, err;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, rd;
    logic [8:0] rx;
    wire [31:0] prd;
    wire prdy, perr, sclk, din, dout, doe, txw, rxw;
    int num_errors = 0, checks = 0, cycles = 0;
    initial forever #10 mclk = ~mclk;
    sync_slave_serial_port i_sync_slave_serial_port (.MCLK_I(mclk), .RST_N_I(rst_n),
        .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa),
        .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
        .SHIFT_CLK_I(sclk), .DATA_IN_I(din), .DATA_OUT_O(dout), .DATA_OE_O(doe),
        .TX_WAKE_O(txw), .RX_WAKE_O(rxw));
    ext_shift_master i_ext_shift_master (.clk_i(mclk), .shift_clk_o(sclk), .data_o(din),
        .data_i(dout));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge mclk);
        pen <= 1;
        @(posedge mclk);
        // only the bench timeout ends a wait
        while (prdy !== 1'b1)
            @(posedge mclk);
        rd = prd;
        err = perr;
        psel <= 0;
        pen <= 0;
        // let the access edge settle before callers look at outputs
        @(negedge mclk);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        check(rd, exp);
    endtask
    task shift(input logic [8:0] tx, input int n);
        i_ext_shift_master.xfer(tx, n, rx);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // cut a hang well past the expected run of under a thousand cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            num_errors++;
            finish_test;
        end
    end
    initial
    begin
        repeat (20) @(posedge mclk);
        rst_n <= 1;
        rdc(`OFF_RCV_STAT, 32'h00);
        rdc(`OFF_TX_STAT, 32'h02);
        rdc(`OFF_FLAGS, 32'h01);
        apb(0, 12'h020, 0);
        check({rd[30:0], err}, 32'h1);
        // writes while the clock enable is low must be lost
        @(posedge mclk);
        ce <= 1'b0;
        apb(1, `OFF_FLAGS, 32'h0c);
        @(posedge mclk);
        ce <= 1'b1;
        rdc(`OFF_FLAGS, 32'h01);
        $display("reset test done");
        apb(1, `OFF_RCV_STAT, 32'h80);
        apb(1, `OFF_TX_STAT, 32'h30);
        apb(1, `OFF_FLAGS, 32'h04);
        check(txw, 1);
        apb(1, `OFF_TX_HOLD, 32'ha5);
        apb(1, `OFF_TX_HOLD, 32'h3c);
        rdc(`OFF_FLAGS, 32'h04);
        rdc(`OFF_TX_STAT, 32'h30);
        check(doe, 1);
        shift(9'h0, 8);
        check(rx, 32'ha5);
        rdc(`OFF_FLAGS, 32'h05);
        check(txw, 1);
        shift(9'h0, 8);
        check(rx, 32'h3c);
        repeat (4) @(posedge mclk);
        rdc(`OFF_TX_STAT, 32'h32);
        apb(1, `OFF_TX_STAT, 32'h71);
        apb(1, `OFF_TX_HOLD, 32'h5a);
        shift(9'h0, 9);
        check(rx, 32'h15a);
        $display("transmit test done");
        apb(1, `OFF_TX_STAT, 32'h10);
        apb(1, `OFF_RCV_STAT, 32'ha0);
        shift(9'h096, 8);
        rdc(`OFF_FLAGS, 32'h05);
        apb(1, `OFF_FLAGS, 32'h08);
        apb(1, `OFF_RCV_STAT, 32'h90);
        shift(9'h096, 8);
        check(rxw, 1);
        rdc(`OFF_FLAGS, 32'h0b);
        rdc(`OFF_RCV_BUF, 32'h96);
        apb(1, `OFF_RCV_STAT, 32'hd0);
        shift(9'h1c3, 9);
        rdc(`OFF_RCV_STAT, 32'hd1);
        rdc(`OFF_RCV_BUF, 32'hc3);
        rdc(`OFF_FLAGS, 32'h09);
        shift(9'h0f0, 9);
        shift(9'h00f, 9);
        apb(0, `OFF_RCV_STAT, 0);
        check(rd[1], 1);
        apb(1, `OFF_RCV_STAT, 32'hc0);
        apb(0, `OFF_RCV_STAT, 0);
        check(rd[2:1], 0);
        $display("receive test done");
        apb(1, `OFF_RCV_STAT, 32'h80);
        apb(1, `OFF_TX_STAT, 32'hb0);
        apb(1, `OFF_TX_HOLD, 32'h11);
        repeat (3) @(posedge mclk);
        check(doe, 0);
        $display("mode test done");
        finish_test;
    end
endmodule
